// File: verilog/ebdv_pkg.sv
// Function
// - Pull the instruction-start marker low in each instruction's first bus cycle.
// - With visibility set, drive internal read data onto the external data bus.
// - With visibility clear, leave the data bus undriven on internal reads.
// - Reset into a normal mode clears the visibility bit.
// - Reset into a special mode sets it; cleared once, it is read-only.
// - Normal modes ignore setting it unless the newer-variant option allows.
// - After software clears it, visibility stays off until the next reset.
// - Visible reads drive the bus outward although the cycle is a read.
// - In expanded modes the two lost ports' addresses go out externally.
// - Handshake interrupts share the external interrupt request vector.
// - Register block and RAM relocate independently to any 4-Kbyte boundary.
// - Normal expanded mode never drives the bus on nonvolatile memory reads.
// - The marker is open-drain active low, released outside that cycle.
package ebdv_pkg;

    typedef enum logic [1:0]
    {
        EBDV_NORMAL_SINGLE,
        EBDV_NORMAL_EXPANDED,
        EBDV_SPECIAL_BOOT,
        EBDV_SPECIAL_TEST
    } ebdv_mode_type;

    typedef struct packed
    {
        logic        cycle_start;
        logic        instr_start;
        logic        read;
        logic [15:0] addr;
    } ebdv_bus_req_type;

    localparam int          EBDV_PAGE_LSB     = 12;
    localparam logic [5:0]  EBDV_REG_SPAN_HI  = 6'h3f;
    localparam logic [7:0]  EBDV_RAM_SPAN_HI  = 8'hff;
    localparam logic [5:0]  EBDV_PORT_LO      = 6'h02;
    localparam logic [5:0]  EBDV_PORT_HI      = 6'h07;
    localparam logic [15:0] EBDV_EEPROM_LO    = 16'hb600;
    localparam logic [15:0] EBDV_EEPROM_HI    = 16'hb7ff;
    localparam logic [15:0] EBDV_ROM_LO       = 16'he000;
    localparam logic [7:0]  EBDV_DATA_RESET   = 8'h00;
    localparam logic [3:0]  EBDV_REG_BASE_RST = 4'h1;
    localparam logic [3:0]  EBDV_RAM_BASE_RST = 4'h0;

endpackage

// File: verilog/ebdv_expansion_debug.sv
`timescale 1ns/10ps
module ebdv_expansion_debug
    import ebdv_pkg::*;
(
    input  wire logic             i_clock,
    input  wire logic             i_reset,
    input  wire logic             i_mode_a_pin,
    input  wire logic             i_mode_b_pin,
    input  wire logic             i_ext_irq_n_pin,
    input  wire ebdv_bus_req_type i_bus,
    input  wire logic [7:0]       i_internal_rdata,
    input  wire logic             i_vis_write,
    input  wire logic             i_vis_wdata,
    input  wire logic             i_newer_variant,
    input  wire logic             i_base_write,
    input  wire logic [3:0]       i_reg_base,
    input  wire logic [3:0]       i_ram_base,
    input  wire logic             i_onchip_rom_enable,
    input  wire logic             i_handshake_irq,
    output logic                  o_instruction_start_marker_o,
    output logic                  o_instruction_start_marker_oe,
    output logic [7:0]            o_data_o,
    output logic                  o_data_oe,
    output logic                  o_external_access,
    output logic                  o_internal_read_visibility,
    output logic                  o_mode_ready,
    output logic                  o_irq_request
);

    // Pin synchronisers
    logic [2:0] sync1_q;
    logic [2:0] sync1_d;
    logic [2:0] sync2_q;
    logic [2:0] sync2_d;

    always_comb
    begin
        sync1_d = {i_ext_irq_n_pin, i_mode_b_pin, i_mode_a_pin};
        sync2_d = sync1_q;
    end

    // No reset, so straps settle while reset is held
    always_ff @(posedge i_clock)
    begin
        sync1_q <= sync1_d;
        sync2_q <= sync2_d;
    end

    // Mode capture and visibility bit
    ebdv_mode_type mode_q;
    ebdv_mode_type mode_d;
    logic          init_q;
    logic          init_d;
    logic          ready_q;
    logic          ready_d;
    logic          irv_q;
    logic          irv_d;
    logic          locked_q;
    logic          locked_d;
    logic [3:0]    reg_base_q;
    logic [3:0]    reg_base_d;
    logic [3:0]    ram_base_q;
    logic [3:0]    ram_base_d;
    logic          special;
    logic          expanded;

    always_comb
    begin
        special  = (mode_q == EBDV_SPECIAL_BOOT) ||
                   (mode_q == EBDV_SPECIAL_TEST);
        expanded = (mode_q == EBDV_NORMAL_EXPANDED) ||
                   (mode_q == EBDV_SPECIAL_TEST);
    end

    always_comb
    begin
        mode_d     = mode_q;
        init_d     = 1'b0;
        ready_d    = ready_q | init_q;
        irv_d      = irv_q;
        locked_d   = locked_q;
        reg_base_d = reg_base_q;
        ram_base_d = ram_base_q;
        if (init_q)
        begin
            // Straps are sampled once, just after reset release
            case ({sync2_q[1], sync2_q[0]})
                2'b10:   mode_d = EBDV_NORMAL_SINGLE;
                2'b11:   mode_d = EBDV_NORMAL_EXPANDED;
                2'b00:   mode_d = EBDV_SPECIAL_BOOT;
                default: mode_d = EBDV_SPECIAL_TEST;
            endcase
            irv_d = ~sync2_q[1];
        end
        else if (ready_q && i_vis_write && !locked_q)
        begin
            if (!i_vis_wdata)
            begin
                irv_d    = 1'b0;
                locked_d = 1'b1;
            end
            else if (special || i_newer_variant)
            begin
                irv_d = 1'b1;
            end
        end
        if (ready_q && i_base_write)
        begin
            reg_base_d = i_reg_base;
            ram_base_d = i_ram_base;
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_reset)
        begin
            mode_q     <= EBDV_NORMAL_SINGLE;
            init_q     <= 1'b1;
            ready_q    <= 1'b0;
            irv_q      <= 1'b0;
            locked_q   <= 1'b0;
            reg_base_q <= EBDV_REG_BASE_RST;
            ram_base_q <= EBDV_RAM_BASE_RST;
        end
        else
        begin
            mode_q     <= mode_d;
            init_q     <= init_d;
            ready_q    <= ready_d;
            irv_q      <= irv_d;
            locked_q   <= locked_d;
            reg_base_q <= reg_base_d;
            ram_base_q <= ram_base_d;
        end
    end

    // Internal address decode
    logic reg_hit;
    logic ram_hit;
    logic port_hit;
    logic nvm_hit;
    logic internal;
    logic nvm_block;

    always_comb
    begin
        reg_hit  = (i_bus.addr[15:EBDV_PAGE_LSB] == reg_base_q) &&
                   (i_bus.addr[11:6] == 6'h00);
        ram_hit  = (i_bus.addr[15:EBDV_PAGE_LSB] == ram_base_q) &&
                   (i_bus.addr[11:8] == 4'h0) && !reg_hit;
        port_hit = reg_hit && (i_bus.addr[5:0] >= EBDV_PORT_LO) &&
                   (i_bus.addr[5:0] <= EBDV_PORT_HI);
        nvm_hit  = ((i_bus.addr >= EBDV_EEPROM_LO) &&
                    (i_bus.addr <= EBDV_EEPROM_HI)) ||
                   (i_onchip_rom_enable && (i_bus.addr >= EBDV_ROM_LO));
        nvm_hit  = nvm_hit && !reg_hit && !ram_hit;
        // Lost ports decode external when expanded
        internal = (reg_hit && !(expanded && port_hit)) ||
                   ram_hit || nvm_hit;
        // Nonvolatile reads stay quiet in normal expanded
        nvm_block = nvm_hit && (mode_q == EBDV_NORMAL_EXPANDED);
    end

    // Bus cycle outputs: enables and external access held for the full bus cycle, data = i_internal_rdata at cycle start or if data_oe_q, else EBDV_DATA_RESET
    logic       marker_oe_q;
    logic       marker_oe_d;
    logic       data_oe_q;
    logic       data_oe_d;
    logic [7:0] data_q;
    logic [7:0] data_d;
    logic       ext_q;
    logic       ext_d;
    logic       irq_q;
    logic       irq_d;

    always_comb
    begin
        marker_oe_d = marker_oe_q;
        data_oe_d   = data_oe_q;
        ext_d       = ext_q;
        data_d      = data_oe_q ? i_internal_rdata : EBDV_DATA_RESET;
        if (i_bus.cycle_start && ready_q)
        begin
            // Low only for the first cycle
            marker_oe_d = i_bus.instr_start;
            data_oe_d   = irv_q && i_bus.read && internal && !nvm_block;
            data_d      = i_internal_rdata;
            ext_d       = expanded && !internal;
        end
        irq_d = i_handshake_irq || !sync2_q[2];
    end

    always_ff @(posedge i_clock)
    begin
        if (i_reset)
        begin
            marker_oe_q <= 1'b0;
            data_oe_q   <= 1'b0;
            data_q      <= EBDV_DATA_RESET;
            ext_q       <= 1'b0;
            irq_q       <= 1'b0;
        end
        else
        begin
            marker_oe_q <= marker_oe_d;
            data_oe_q   <= data_oe_d;
            data_q      <= data_d;
            ext_q       <= ext_d;
            irq_q       <= irq_d;
        end
    end

    // Open-drain marker only ever drives low
    always_ff @(posedge i_clock)
    begin
        o_instruction_start_marker_o <= 1'b0;
    end

    always_comb
    begin
        o_instruction_start_marker_oe = marker_oe_q;
        o_data_o                      = data_q;
        o_data_oe                     = data_oe_q;
        o_external_access             = ext_q;
        o_internal_read_visibility    = irv_q;
        o_mode_ready                  = ready_q;
        o_irq_request                 = irq_q;
    end

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_reset);

    sequence vis_start;
        i_bus.cycle_start && ready_q && irv_q && i_bus.read &&
        internal && !nvm_block;
    endsequence

    sequence hold_cycle;
        !i_bus.cycle_start;
    endsequence

    AST_MARKER_LOW: assert property (
        i_bus.cycle_start && ready_q && i_bus.instr_start |=>
        o_instruction_start_marker_oe && !o_instruction_start_marker_o)
        else $error("Marker not pulled low on instruction start");

    AST_MARKER_RELEASE: assert property (
        i_bus.cycle_start && ready_q && !i_bus.instr_start |=>
        !o_instruction_start_marker_oe)
        else $error("Marker not released");

    AST_VIS_DRIVE: assert property (
        vis_start |=> o_data_oe && (o_data_o == $past(i_internal_rdata)))
        else $error("Visible read data not driven");

    AST_VIS_OFF: assert property (
        i_bus.cycle_start && ready_q && !irv_q |=> !o_data_oe)
        else $error("Bus driven with visibility off");

    AST_NORMAL_START: assert property (
        !i_reset && init_q && sync2_q[1] |=> !irv_q [*2])
        else $error("Visibility set after normal reset");

    AST_SPECIAL_START: assert property (
        !i_reset && init_q && !sync2_q[1] |=> irv_q)
        else $error("Visibility clear after special reset");

    AST_NORMAL_SET_IGNORED: assert property (
        ready_q && !special && !i_newer_variant && !irv_q |=> !irv_q)
        else $error("Visibility set in normal mode");

    AST_LOCKED: assert property (
        $fell(irv_q) && !init_q |-> locked_q ##1 !irv_q [*3])
        else $error("Visibility re-enabled after clear");

    AST_OUTWARD_HOLD: assert property (
        vis_start ##1 hold_cycle |=> o_data_oe)
        else $error("Visible drive dropped within bus cycle");

    AST_PORTS_EXTERNAL: assert property (
        i_bus.cycle_start && ready_q && expanded && port_hit |=>
        o_external_access)
        else $error("Lost port access kept internal");

    AST_IRQ_SHARED: assert property (
        i_handshake_irq |=> o_irq_request)
        else $error("Handshake interrupt not on shared vector");

    AST_NVM_QUIET: assert property (
        i_bus.cycle_start && ready_q && nvm_block |=> !o_data_oe)
        else $error("Bus driven on nonvolatile read");

endmodule

// File: testbench/ebdv_ext_partner.sv
`timescale 1ns/10ps
module ebdv_ext_partner
(
    input  wire logic        i_clock,
    input  wire logic [15:0] i_addr,
    input  wire logic        i_read,
    input  wire logic        i_external_access,
    input  wire logic        i_data_oe,
    input  wire logic [7:0]  i_data_o,
    output logic [7:0]       o_bus,
    output logic             o_contention,
    output logic             o_ram_wr_n
);
    logic       eprom_sel;
    logic       ram_rd_n;
    logic       ram_wr_n;
    logic       ext_drive;
    logic [7:0] ext_data;
    logic [7:0] last_q;

    assign eprom_sel = i_addr[15] & i_addr[13];
    assign ram_rd_n  = ~((i_addr[15:14] == 2'b00) & i_read &
                         i_external_access);
    assign ram_wr_n  = ~((i_addr[15:14] == 2'b00) & ~i_read &
                         i_external_access);
    assign o_ram_wr_n = ram_wr_n;
    assign ext_drive = i_external_access & i_read & (eprom_sel | ~ram_rd_n);
    assign ext_data  = eprom_sel ? (i_addr[7:0] ^ 8'h5a) : i_addr[7:0];

    // Released bus shows no stale value
    always_ff @(posedge i_clock)
    begin
        last_q <= o_bus;
    end

    assign o_bus = i_data_oe ? i_data_o : (ext_drive ? ext_data : ~last_q);
    assign o_contention = i_data_oe & ext_drive;
endmodule

// File: testbench/testbench.sv
`timescale 1ns/10ps
module testbench;
    import ebdv_pkg::*;
    logic clock = 0, reset = 1, mode_a = 0, mode_b = 0, irq_n = 1;
    ebdv_bus_req_type bus = '0;
    logic [7:0] rdata = 8'h00;
    logic vis_write = 0, vis_wdata = 0, newer = 0, base_write = 0;
    logic [3:0] reg_base = 4'h1, ram_base = 4'h0;
    logic rom_en = 0, hs_irq = 0;
    logic mk_o, mk_oe, d_oe, ext, vis, ready, irq, contention, ram_wr_n;
    logic [7:0] d_o, bus_level, r;
    logic [1:0] codes [4] = '{2'b10, 2'b11, 2'b00, 2'b01};
    int n_errors = 0, comparisons = 0, seed = 50416;

    always #4 clock = ~clock;

    ebdv_expansion_debug u_ebdv_expansion_debug (
        .i_clock(clock), .i_reset(reset), .i_mode_a_pin(mode_a),
        .i_mode_b_pin(mode_b), .i_ext_irq_n_pin(irq_n), .i_bus(bus),
        .i_internal_rdata(rdata), .i_vis_write(vis_write),
        .i_vis_wdata(vis_wdata), .i_newer_variant(newer),
        .i_base_write(base_write), .i_reg_base(reg_base),
        .i_ram_base(ram_base), .i_onchip_rom_enable(rom_en),
        .i_handshake_irq(hs_irq), .o_instruction_start_marker_o(mk_o),
        .o_instruction_start_marker_oe(mk_oe), .o_data_o(d_o),
        .o_data_oe(d_oe), .o_external_access(ext),
        .o_internal_read_visibility(vis), .o_mode_ready(ready),
        .o_irq_request(irq));

    ebdv_ext_partner u_ebdv_ext_partner (
        .i_clock(clock), .i_addr(bus.addr), .i_read(bus.read),
        .i_external_access(ext), .i_data_oe(d_oe), .i_data_o(d_o),
        .o_bus(bus_level), .o_contention(contention),
        .o_ram_wr_n(ram_wr_n));

    function automatic logic exp_vis_reset(logic [1:0] code);
        return (code == 2'b00) || (code == 2'b01);
    endfunction

    task automatic conclude();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check_bit(string name, logic exp, logic got);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic check_byte(string name, logic [7:0] exp, logic [7:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Straps held across reset so the synchronisers settle
    task automatic do_reset(logic [1:0] code);
        int k;
        k = 0;
        @(posedge clock);
        {mode_b, mode_a} <= code;
        reset <= 1;
        repeat (3) @(posedge clock);
        reset <= 0;
        while (ready !== 1'b1 && k < 10)
        begin
            @(posedge clock);
            k++;
        end
        check_bit("mode_ready", 1'b1, ready);
        if (ready !== 1'b1)
            conclude();
        else
        begin
            @(posedge clock);
            #1;
        end
    endtask

    task automatic cycle(logic instr, logic rd, logic [15:0] addr);
        @(posedge clock);
        bus <= {1'b1, instr, rd, addr};
        rdata <= r;
        @(posedge clock);
        bus.cycle_start <= 1'b0;
        @(posedge clock);
        #1;
    endtask

    task automatic vis_wr(logic v);
        @(posedge clock);
        vis_write <= 1'b1;
        vis_wdata <= v;
        @(posedge clock);
        vis_write <= 1'b0;
        @(posedge clock);
        #1;
    endtask

    initial
    begin
        for (int m = 0; m < 4; m++)
        begin
            do_reset(codes[m]);
            check_bit("vis_reset", exp_vis_reset(codes[m]), vis);
        end
        for (int i = 0; i < 4; i++)
        begin
            r = 8'($random(seed));
            cycle(1'b1, 1'b1, {8'h00, 8'($random(seed))});
            check_bit("marker_oe", 1'b1, mk_oe);
            check_bit("marker_o", 1'b0, mk_o);
            check_bit("data_oe", 1'b1, d_oe);
            check_byte("data_o", r, d_o);
            check_byte("bus_level", r, bus_level);
            check_bit("contention", 1'b0, contention);
        end
        cycle(1'b0, 1'b0, 16'h0020);
        check_bit("marker_idle", 1'b0, mk_oe);
        vis_wr(1'b0);
        check_bit("vis_clear", 1'b0, vis);
        vis_wr(1'b1);
        check_bit("vis_locked", 1'b0, vis);
        cycle(1'b1, 1'b1, 16'h0030);
        check_bit("data_oe_off", 1'b0, d_oe);
        do_reset(2'b11);
        vis_wr(1'b1);
        check_bit("vis_refused", 1'b0, vis);
        @(posedge clock);
        newer <= 1'b1;
        vis_wr(1'b1);
        check_bit("vis_newer", 1'b1, vis);
        cycle(1'b1, 1'b1, EBDV_EEPROM_LO);
        check_bit("nvm_oe", 1'b0, d_oe);
        cycle(1'b0, 1'b1, 16'h0040);
        check_bit("ram_oe", 1'b1, d_oe);
        for (int p = 2; p < 8; p++)
        begin
            cycle(1'b0, 1'b1, 16'h1000 + 16'(p));
            check_bit("lost_port", 1'b1, ext);
        end
        cycle(1'b0, 1'b1, 16'h1008);
        check_bit("reg_internal", 1'b0, ext);
        cycle(1'b0, 1'b1, 16'ha005);
        check_byte("eprom_low", 8'h05 ^ 8'h5a, bus_level);
        cycle(1'b0, 1'b1, 16'he005);
        check_byte("eprom_high", 8'h05 ^ 8'h5a, bus_level);
        cycle(1'b0, 1'b0, 16'h1003);
        check_bit("ram_wr_n", 1'b0, ram_wr_n);
        @(posedge clock);
        rom_en <= 1'b1;
        cycle(1'b0, 1'b1, 16'he005);
        check_bit("rom_oe", 1'b0, d_oe);
        check_bit("rom_internal", 1'b0, ext);
        @(posedge clock);
        rom_en <= 1'b0;
        @(posedge clock);
        base_write <= 1'b1;
        reg_base <= 4'h4;
        ram_base <= 4'h2;
        @(posedge clock);
        base_write <= 1'b0;
        cycle(1'b0, 1'b1, 16'h4003);
        check_bit("moved_port", 1'b1, ext);
        cycle(1'b0, 1'b1, 16'h2010);
        check_bit("moved_ram", 1'b0, ext);
        cycle(1'b0, 1'b1, 16'h0010);
        check_bit("old_ram", 1'b1, ext);
        @(posedge clock);
        hs_irq <= 1'b1;
        repeat (2) @(posedge clock);
        #1;
        check_bit("irq_hs", 1'b1, irq);
        @(posedge clock);
        hs_irq <= 1'b0;
        irq_n <= 1'b0;
        repeat (5) @(posedge clock);
        #1;
        check_bit("irq_pin", 1'b1, irq);
        @(posedge clock);
        irq_n <= 1'b1;
        repeat (5) @(posedge clock);
        #1;
        check_bit("irq_idle", 1'b0, irq);
        conclude();
    end
endmodule
